// ===== rtl/half_rate_clock_gen.sv
// half-rate in-phase and quadrature clock forwarding
`timescale 1ns/1ps
module half_rate_clock_gen
  import pixel_port_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic run,
  output logic      clk_half_i,
  output logic      clk_half_q
);

  // in-phase divide
  // in-phase copy toggles on each rising pixel edge while running
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      clk_half_i <= 1'b0;
    end else begin
      clk_half_i <= ~clk_half_i;
    end
  end

  // quadrature copy
  // falling edge retimes the in-phase copy, giving a quarter-period lag
  always_ff @(negedge clk) begin
    if (reset || !run) begin
      clk_half_q <= 1'b0;
    end else begin
      clk_half_q <= clk_half_i;
    end
  end

  chk_half_toggle : assert property (
    @(posedge clk) disable iff (reset)
    (run && $past(run)) |-> (clk_half_i != $past(clk_half_i)))
    else $error("in-phase half clock did not toggle");

  chk_quad_lag : assert property (
    @(posedge clk) disable iff (reset)
    (run [*3]) |-> (clk_half_q == clk_half_i))
    else $error("quadrature clock not a quarter period behind");

endmodule

// ===== rtl/pixel_output_port.sv
// transmit side of the digital pixel output port
`timescale 1ns/1ps
module pixel_output_port
  import pixel_port_pkg::*;
#(
  parameter int PIXEL_CLOCK_KHZ = PIXEL_CLOCK_NOM_KHZ,
  parameter int DATA_LEAD       = BLANK_LEAD_CLOCKS
)(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire rgb_s                  pixel_in,
  input  wire logic [LUMA_WIDTH-1:0] luma_in,
  input  wire logic                  active_video_in,
  input  wire timing_s               timing_in,
  input  wire logic                  frame_start,
  input  wire logic                  luminance_mode_sel,
  input  wire logic                  cable_present,
  input  wire logic                  receiver_power_indicator,
  output rgb_s                       rgb_out,
  output logic                       active_video_indicator,
  output timing_s                    timing_out,
  output logic                       data_drive_enable,
  output logic                       link_enable,
  output logic                       clk_half_i,
  output logic                       clk_half_q
);

  // clock band check
  // the datapath is one pixel per clock at any rate; refuse rates outside the band
  if (PIXEL_CLOCK_KHZ < PIXEL_CLOCK_MIN_KHZ || PIXEL_CLOCK_KHZ > PIXEL_CLOCK_MAX_KHZ) begin
    $error("pixel clock outside supported band");
  end
  // the last pipeline stage is indexed, so at least one stage must exist
  if (DATA_LEAD < 1) begin
    $error("data lead must be at least one stage");
  end

  link_state_e link_state;
  link_state_e next_link_state;
  logic        luma_mode;
  slot_s       next_slot;
  slot_s       pipe [DATA_LEAD];
  logic        run_ok;
  logic        data_ok;

  // link power state follows the cable and the receiver supply
  always_comb begin
    next_link_state = LINK_OFF;
    case (link_state)
      LINK_OFF: begin
        if (receiver_power_indicator) begin
          next_link_state = LINK_IDLE;
        end
      end
      LINK_IDLE: begin
        if (!receiver_power_indicator) begin
          next_link_state = LINK_OFF;
        end else if (cable_present) begin
          next_link_state = LINK_RUN;
        end else begin
          next_link_state = LINK_IDLE;
        end
      end
      LINK_RUN: begin
        if (!receiver_power_indicator) begin
          next_link_state = LINK_OFF;
        end else if (!cable_present) begin
          next_link_state = LINK_IDLE;
        end else begin
          next_link_state = LINK_RUN;
        end
      end
      default: begin
        next_link_state = LINK_OFF;
      end
    endcase
  end

  // supply loss shutdown
  // a bad supply forces off at once, without waiting for the state register
  assign run_ok  = receiver_power_indicator && (link_state != LINK_OFF);
  assign data_ok = run_ok && cable_present && (link_state == LINK_RUN);

  always_ff @(posedge clk) begin
    if (reset) begin
      link_state <= LINK_OFF;
    end else begin
      link_state <= next_link_state;
    end
  end

  // frame-boundary mode latch
  // a change mid-frame would tear the picture, so it waits for the frame start
  always_ff @(posedge clk) begin
    if (reset) begin
      luma_mode <= 1'b0;
    end else if (frame_start) begin
      luma_mode <= luminance_mode_sel;
    end
  end

  // pack the pixel according to the active mode
  always_comb begin
    next_slot.tim = timing_in;
    if (luma_mode) begin
      // top twelve on red and green
      next_slot.pix.red   = luma_in[LUMA_WIDTH-1:LUMA_HI_LSB];
      next_slot.pix.green = luma_in[LUMA_WIDTH-1:LUMA_HI_LSB];
      // top eight repeated on blue high
      next_slot.pix.blue[COMP_WIDTH-1:BLUE_DUP_LSB] = luma_in[LUMA_WIDTH-1:LUMA_TOP_LSB];
      next_slot.pix.blue[LUMA_LO_WIDTH-1:0] = luma_in[LUMA_LO_WIDTH-1:0];
    end else begin
      next_slot.pix = pixel_in;
    end
  end

  // data delay line
  // data sits DATA_LEAD stages longer than the indicator, giving the fixed lead
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DATA_LEAD; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      pipe[0] <= next_slot;
      for (int i = 1; i < DATA_LEAD; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // data drivers quiet without a cable
  always_ff @(posedge clk) begin
    if (reset || !data_ok) begin
      rgb_out <= '{red: COMP_IDLE, green: COMP_IDLE, blue: COMP_IDLE};
    end else begin
      rgb_out <= pipe[DATA_LEAD-1].pix;
    end
  end

  // control outputs dropped on a bad supply
  always_ff @(posedge clk) begin
    if (reset || !run_ok) begin
      active_video_indicator <= 1'b0;
      timing_out             <= '0;
    end else begin
      active_video_indicator <= active_video_in;
      timing_out             <= pipe[DATA_LEAD-1].tim;
    end
  end

  // enables shown to the pad drivers, also flops
  always_ff @(posedge clk) begin
    if (reset) begin
      data_drive_enable <= 1'b0;
      link_enable       <= 1'b0;
    end else begin
      data_drive_enable <= data_ok;
      link_enable       <= run_ok;
    end
  end

  // forwarded half-rate clocks
  // clocks stop with the interface so the drivers never feed an unpowered receiver
  half_rate_clock_gen u_clk_fwd (
    .clk        (clk),
    .reset      (reset),
    .run        (run_ok),
    .clk_half_i (clk_half_i),
    .clk_half_q (clk_half_q)
  );

  // a running link held long enough to fill the whole data path
  sequence s_link_steady;
    data_ok [*5];
  endsequence

  // two clocks of live data in a row
  sequence s_link_pair;
    data_ok ##1 data_ok;
  endsequence

  chk_out_registered : assert property (
    @(posedge clk) disable iff (reset)
    $past(data_ok) |-> (rgb_out == $past(pipe[DATA_LEAD-1].pix)))
    else $error("data output not launched from the last stage");

  chk_one_per_clock : assert property (
    @(posedge clk) disable iff (reset)
    s_link_pair |-> (rgb_out == $past(pipe[DATA_LEAD-1].pix)
                     && pipe[0] == $past(next_slot)))
    else $error("a pixel was skipped or repeated");

  chk_luma_red_green : assert property (
    @(posedge clk) disable iff (reset)
    $past(luma_mode) |-> (pipe[0].pix.red == $past(luma_in[LUMA_WIDTH-1:LUMA_HI_LSB])
                          && pipe[0].pix.green == $past(luma_in[LUMA_WIDTH-1:LUMA_HI_LSB])))
    else $error("luminance top bits missing on red or green");

  chk_luma_blue_low : assert property (
    @(posedge clk) disable iff (reset)
    $past(luma_mode) |-> (pipe[0].pix.blue[LUMA_LO_WIDTH-1:0]
                          == $past(luma_in[LUMA_LO_WIDTH-1:0])))
    else $error("luminance low bits missing on blue");

  chk_luma_blue_high : assert property (
    @(posedge clk) disable iff (reset)
    $past(luma_mode) |-> (pipe[0].pix.blue[COMP_WIDTH-1:BLUE_DUP_LSB]
                          == $past(luma_in[LUMA_WIDTH-1:LUMA_TOP_LSB])))
    else $error("luminance top eight missing on blue");

  chk_no_cable_quiet : assert property (
    @(posedge clk) disable iff (reset)
    !cable_present |=> (rgb_out == '0 && !data_drive_enable))
    else $error("data driven without a cable");

  chk_power_shutdown : assert property (
    @(posedge clk) disable iff (reset)
    !receiver_power_indicator |=> (!link_enable && !active_video_indicator
                                   && rgb_out == '0 && timing_out == '0))
    else $error("interface active with receiver supply out of range");

  chk_indicator_lead : assert property (
    @(posedge clk) disable iff (reset)
    s_link_steady |-> (rgb_out == $past(next_slot.pix, 4)
                        && active_video_indicator == $past(active_video_in)))
    else $error("indicator does not lead data by three clocks");

  chk_mode_at_frame : assert property (
    @(posedge clk) disable iff (reset)
    (luma_mode != $past(luma_mode)) |-> $past(frame_start))
    else $error("packing mode changed away from a frame boundary");

endmodule

// ===== rtl/pixel_port_pkg.sv
// shared constants and carriers for the digital pixel output port
package pixel_port_pkg;

  // component and luminance widths
  localparam int COMP_WIDTH = 12;
  localparam int LUMA_WIDTH = 16;
  // luminance field split: upper twelve, lower four, upper eight
  localparam int LUMA_HI_LSB   = 4;
  localparam int LUMA_LO_WIDTH = 4;
  localparam int LUMA_TOP_LSB  = 8;
  localparam int BLUE_DUP_LSB  = 4;

  // supported pixel clock band, in kHz
  localparam int PIXEL_CLOCK_MIN_KHZ = 2500;
  localparam int PIXEL_CLOCK_MAX_KHZ = 175000;
  // nominal pixel clock of this build, in kHz
  localparam int PIXEL_CLOCK_NOM_KHZ = 20000;

  // pixel clocks by which the active-video indicator leads the data
  localparam int BLANK_LEAD_CLOCKS = 3;

  // output value while drivers are shut down
  localparam logic [COMP_WIDTH-1:0] COMP_IDLE = 12'h000;

  // link power state, gray along off -> idle -> run
  typedef enum logic [1:0] {
    LINK_OFF  = 2'b00,
    LINK_IDLE = 2'b01,
    LINK_RUN  = 2'b11
  } link_state_e;

  // one pixel on the three colour buses
  typedef struct packed {
    logic [COMP_WIDTH-1:0] red;
    logic [COMP_WIDTH-1:0] green;
    logic [COMP_WIDTH-1:0] blue;
  } rgb_s;

  // raster timing that travels with the pixel
  typedef struct packed {
    logic csync;
    logic vsync;
    logic field;
    logic swap;
  } timing_s;

  // one pipeline slot
  typedef struct packed {
    rgb_s    pix;
    timing_s tim;
  } slot_s;

endpackage

// ===== verification/tb_digital_pixel_output_port.sv
// testbench for the pixel output port against a cycle model
`timescale 1ns/1ps
module tb_digital_pixel_output_port;
  import pixel_port_pkg::*;
  logic        clk, reset, frame_start, sel, cable, supply_ok, active_in;
  logic        power_ind, regen_clk, av_out, dde, link_en, ck_i, ck_q;
  logic        mode_m, counting, last_i;
  rgb_s        pix_in, rgb_o;
  timing_s     tim_in, tim_o;
  logic [15:0] luma;
  logic [35:0] e_rgb [0:511];
  logic [3:0]  e_tim [0:511];
  logic        e_av  [0:511];
  int          failures, num_checks, n, seed, pw_hi, pw_lo, cb_hi, cb_lo, rises;
  // phase table: length, frame_start, mode select, power, cable
  int          len [8] = '{45, 40, 10, 12, 10, 12, 30, 20};
  logic [7:0]  fsx = 8'ha3;
  logic [7:0]  selx = 8'hde;
  logic [7:0]  pwx = 8'hef;
  logic [7:0]  cbx = 8'hfb;

  pixel_output_port #(.PIXEL_CLOCK_KHZ(20000)) pixel_output_port_i (
    .clk(clk), .reset(reset), .pixel_in(pix_in), .luma_in(luma),
    .active_video_in(active_in), .timing_in(tim_in), .frame_start(frame_start),
    .luminance_mode_sel(sel), .cable_present(cable), .receiver_power_indicator(power_ind),
    .rgb_out(rgb_o), .active_video_indicator(av_out), .timing_out(tim_o),
    .data_drive_enable(dde), .link_enable(link_en), .clk_half_i(ck_i), .clk_half_q(ck_q));

  video_receiver_model video_receiver_model_i (
    .supply_ok(supply_ok), .clk_half_i(ck_i), .clk_half_q(ck_q),
    .receiver_power_indicator(power_ind), .regen_clk(regen_clk));

  // 20 MHz pixel clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // counts regenerated pixel clocks while a window is open
  always @(posedge regen_clk) begin
    if (counting) rises++;
  end

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one pixel clock: judge settled outputs, then present the next pixel
  task automatic step(input logic fs, input logic s, input logic p, input logic c);
    logic [63:0] r;
    @(posedge clk);
    #1;
    // only judge once a condition has held long enough to be past its transition
    if (pw_lo >= 2) begin
      check("off_rgb", rgb_o, 36'h0);
      check("off_misc", {av_out, tim_o, dde, link_en, ck_i, ck_q}, 36'h0);
    end
    if (pw_hi >= 6) begin
      check("link", link_en, 36'h1);
      check("active", av_out, e_av[n-1]);
      check("timing", tim_o, e_tim[n-4]);
      check("half_i", ck_i, {~last_i});
      check("quad", ck_q, {~ck_i});
      if (cb_hi >= 6) begin
        check("rgb", rgb_o, e_rgb[n-4]);
        check("drive_on", dde, 36'h1);
      end
      if (cb_lo >= 2) begin
        check("gated_rgb", rgb_o, 36'h0);
        check("drive_off", dde, 36'h0);
      end
    end
    last_i = ck_i;
    r = {$random(seed), $random(seed)};
    pix_in = r[35:0];
    luma = r[63:48];
    tim_in = r[47:44];
    active_in = r[43];
    frame_start = fs;
    sel = s;
    supply_ok = p;
    cable = c;
    e_av[n] = active_in;
    e_tim[n] = tim_in;
    e_rgb[n] = mode_m ? {luma[15:4], luma[15:4], luma[15:8], luma[3:0]} : pix_in;
    // new packing applies to the pixel after the boundary
    if (fs) mode_m = s;
    pw_hi = p ? pw_hi + 1 : 0;
    pw_lo = p ? 0 : pw_lo + 1;
    cb_hi = c ? cb_hi + 1 : 0;
    cb_lo = c ? 0 : cb_lo + 1;
    n++;
  endtask

  // main sequence: every phase runs a fixed count, so nothing can hang
  initial begin
    seed = 70;
    {failures, num_checks, n, pw_hi, pw_lo, cb_hi, cb_lo, rises} = '0;
    {counting, mode_m, last_i, frame_start, sel, cable, supply_ok, active_in} = '0;
    reset = 1'b1;
    pix_in = '0;
    luma = '0;
    tim_in = '0;
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    for (int ph = 0; ph < 8; ph++) begin
      for (int j = 0; j < len[ph]; j++) begin
        if (ph == 0 && j == 10) counting = 1'b1;
        if (ph == 0 && j == 40) begin
          counting = 1'b0;
          check("regen", 36'(rises), 36'h1e);
        end
        step(j == 0 && fsx[ph], selx[ph], pwx[ph], cbx[ph]);
      end
    end
    give_verdict();
  end
endmodule

// ===== verification/video_receiver_model.sv
// receiver board model: power indicator and direct clock regeneration
`timescale 1ns/1ps
module video_receiver_model (
  input  wire logic supply_ok,
  input  wire logic clk_half_i,
  input  wire logic clk_half_q,
  output logic      receiver_power_indicator,
  output logic      regen_clk
);
  // sole load on the link
  // indicator follows this board's own receiver supply
  assign receiver_power_indicator = supply_ok;
  // no pll recovery
  // i xor q rises once per pixel clock at any rate, so no lock range to worry about
  assign regen_clk = clk_half_i ^ clk_half_q;
endmodule
